// *** design/bridge_ctl_pkg.sv ***
// bridge control package: register map, field positions, reset values, decode ranges
// assumes a 32-bit classic wishbone register bus
package bridge_ctl_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] BRIDGE_CONTROL_OFF = 4'h0;
   localparam logic [3:0] COMMAND_OFF = 4'h4;
   localparam logic [3:0] STATUS_OFF = 4'h8;
   localparam int MAM_BIT = 5;
   localparam int FULL_DECODE_BIT = 4;
   localparam int VGA_BIT = 3;
   localparam int ISA_BIT = 2;
   localparam int SERR_BIT = 1;
   localparam int PERR_BIT = 0;
   localparam int CMD_IO_BIT = 0;
   localparam int CMD_MEM_BIT = 1;
   localparam int CMD_SERR_BIT = 8;
   localparam logic [5:0] BRIDGE_CONTROL_RST = 6'h00;
   localparam logic [8:0] COMMAND_RST = 9'h000;
   localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
   localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;
   localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
   localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
   localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
   localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
   localparam logic [9:0] ISA_TOP_START = 10'h100;
   localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// *** design/bridge_forwarding_error_control.sv ***
// bridge control bits and the forwarding / error decisions they steer
// assumes one clock; transaction inputs are sampled at their start pulse
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// What this block does
// [RL1] mam clear: reads all ones, writes dropped
// [RL2] mam set: pci master abort gives ur
// [RL3] mam set: express ur gives target abort
// [RL4] mam gates posted write abort reporting
// [RL5] full decode adds address bits 15:10
// [RL6] vga on: forward a0000-bffff memory down
// [RL7] vga on: forward legacy display io down
// [RL8] vga on: block those addresses going up
// [RL9] vga forwarding ignores isa and windows
// [RL10] vga forwarding needs io/memory enables
// [RL11] vga off: forward only by windows
// [RL12] isa acts inside io window, first 64k
// [RL13] isa on: block top 768 bytes down
// [RL14] isa on: top 768 bytes forward up
// [RL15] isa off: whole io window downstream
// [RL16] serr forwarded only with both enables
// [RL17] parity bit gates secondary error reporting
// [RL18] data error always forwards poisoned data
// [RL19] six bits reset zero, read-write
// [RL20] changes apply to later transactions, except serr forwarding, which follows the live bits
module bridge_forwarding_error_control
   import bridge_ctl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [bridge_ctl_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // transaction to decode and its window hits
   input wire logic txn_start,
   input wire logic txn_upstream,
   input wire logic txn_is_io,
   input wire logic [31:0] txn_addr,
   input wire logic io_window_hit,
   input wire logic mem_window_hit,
   input wire logic pref_window_hit,
   output logic fwd_valid,
   output logic fwd_forward,
   // completion handling
   input wire logic pci_master_abort,
   input wire logic pci_read,
   input wire logic pci_posted_write,
   input wire logic pcie_ur_cpl,
   output logic pcie_ur_resp,
   output logic pci_target_abort,
   output logic read_all_ones,
   output logic [31:0] read_data_fill,
   output logic write_discard,
   output logic posted_abort_report,
   // errors
   input wire logic sec_serr,
   input wire logic sec_addr_err,
   input wire logic sec_attr_err,
   input wire logic sec_data_err,
   output logic serr_forward,
   output logic sec_err_report,
   output logic poison_forward
);
   import bridge_ctl_pkg::*;

   logic [5:0] ctl_q;
   logic [8:0] cmd_q;
   logic [5:0] txn_ctl_q;
   logic [8:0] txn_cmd_q;
   logic wb_hit;
   logic wb_commit;
   logic [31:0] rd_d;

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                       input logic s);
      lane = s ? nw : old;
   endfunction

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // writes land at the edge where the master sees ack high
   assign wb_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= BRIDGE_CONTROL_RST; // RL19
         cmd_q <= COMMAND_RST;
      end else if (wb_commit) begin
         if (wb_adr_i == BRIDGE_CONTROL_OFF && wb_sel_i[0]) begin
            ctl_q <= wb_dat_i[5:0]; // RL19
         end
         if (wb_adr_i == COMMAND_OFF) begin
            cmd_q[7:0] <= lane(cmd_q[7:0], wb_dat_i[7:0], wb_sel_i[0]);
            if (wb_sel_i[1]) begin
               cmd_q[8] <= wb_dat_i[8];
            end
         end
      end
   end

   always_comb begin
      rd_d = UNMAPPED_DATA;
      if (wb_adr_i == BRIDGE_CONTROL_OFF) begin
         rd_d = {26'h0000000, ctl_q};
      end else if (wb_adr_i == COMMAND_OFF) begin
         rd_d = {23'h000000, cmd_q};
      end else if (wb_adr_i == STATUS_OFF) begin
         rd_d = {29'h00000000, fwd_forward, serr_forward, sec_err_report};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= UNMAPPED_DATA;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= wb_hit ? rd_d : UNMAPPED_DATA;
      end
   end

   // settings captured at transaction start
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txn_ctl_q <= BRIDGE_CONTROL_RST;
         txn_cmd_q <= COMMAND_RST;
      end else if (txn_start) begin
         txn_ctl_q <= ctl_q; // RL20
         txn_cmd_q <= cmd_q; // RL20
      end
   end

   // forwarding decode, uses live bits since the start pulse is the capture edge
   logic vga_mem, vga_io, vga_on, isa_top, io_low, fwd_d;
   always_comb begin
      vga_on = ctl_q[VGA_BIT];
      vga_mem = !txn_is_io && in_range(txn_addr, VGA_MEM_LO, VGA_MEM_HI); // RL6
      vga_io = txn_is_io && (txn_addr[31:16] == 16'h0000) // RL7
         && ((txn_addr[9:0] >= VGA_IO_A_LO && txn_addr[9:0] <= VGA_IO_A_HI)
            || (txn_addr[9:0] >= VGA_IO_B_LO && txn_addr[9:0] <= VGA_IO_B_HI))
         && (!ctl_q[FULL_DECODE_BIT] || txn_addr[15:10] == 6'h00); // RL5
      io_low = txn_addr[31:16] == 16'h0000; // RL12
      isa_top = io_low && (txn_addr[9:0] >= ISA_TOP_START);
      fwd_d = 1'b0;
      if (!txn_upstream) begin
         if (vga_on && vga_io) begin
            fwd_d = cmd_q[CMD_IO_BIT]; // RL9 RL10
         end else if (vga_on && vga_mem) begin
            fwd_d = cmd_q[CMD_MEM_BIT]; // RL9 RL10
         end else if (txn_is_io) begin
            fwd_d = cmd_q[CMD_IO_BIT] && io_window_hit // RL11 RL15
               && !(ctl_q[ISA_BIT] && isa_top); // RL13
         end else begin
            fwd_d = cmd_q[CMD_MEM_BIT] && (mem_window_hit || pref_window_hit); // RL11
         end
      end else begin
         if (vga_on && (vga_io || vga_mem)) begin
            fwd_d = 1'b0; // RL8
         end else if (txn_is_io) begin
            fwd_d = !io_window_hit || (ctl_q[ISA_BIT] && isa_top); // RL14
         end else begin
            fwd_d = !(mem_window_hit || pref_window_hit);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fwd_valid <= 1'b0;
         fwd_forward <= 1'b0;
      end else begin
         fwd_valid <= txn_start;
         if (txn_start) begin
            fwd_forward <= fwd_d;
         end
      end
   end

   // completion responses, using the captured settings; below, serr forwarding uses the live bits and error reporting the captured ones
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcie_ur_resp <= 1'b0;
         pci_target_abort <= 1'b0;
         read_all_ones <= 1'b0;
         read_data_fill <= UNMAPPED_DATA;
         write_discard <= 1'b0;
         posted_abort_report <= 1'b0;
      end else begin
         pcie_ur_resp <= pci_master_abort && txn_ctl_q[MAM_BIT]; // RL2
         pci_target_abort <= pcie_ur_cpl && txn_ctl_q[MAM_BIT]; // RL3
         read_all_ones <= (pci_master_abort || pcie_ur_cpl) && pci_read
            && !txn_ctl_q[MAM_BIT]; // RL1
         read_data_fill <= ((pci_master_abort || pcie_ur_cpl) && pci_read
            && !txn_ctl_q[MAM_BIT]) ? ALL_ONES : UNMAPPED_DATA; // RL1
         write_discard <= (pci_master_abort || pcie_ur_cpl) && !pci_read
            && !txn_ctl_q[MAM_BIT]; // RL1
         posted_abort_report <= pci_master_abort && pci_posted_write
            && txn_ctl_q[MAM_BIT]; // RL4
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serr_forward <= 1'b0;
         sec_err_report <= 1'b0;
         poison_forward <= 1'b0;
      end else begin
         serr_forward <= sec_serr && ctl_q[SERR_BIT] && cmd_q[CMD_SERR_BIT]; // RL16
         sec_err_report <= (sec_addr_err || sec_attr_err || sec_data_err)
            && txn_ctl_q[PERR_BIT]; // RL17
         poison_forward <= sec_data_err; // RL18
      end
   end
endmodule

// *** sim/bridge_far_side.sv ***
// far side model: pci bus events and express completions
// assumes the bench holds each event code for one cycle
`timescale 1ns/1ps
module bridge_far_side (
   input wire logic [5:0] ev,
   output logic pci_master_abort,
   output logic pci_read,
   output logic pci_posted_write,
   output logic pcie_ur_cpl,
   output logic sec_serr,
   output logic sec_data_err
);
   assign {sec_data_err, sec_serr, pcie_ur_cpl, pci_posted_write, pci_read,
      pci_master_abort} = ev;
endmodule

// *** sim/bridge_forwarding_error_control_chk.sv ***
// checker for the bridge control block, bound to its ports
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module bridge_forwarding_error_control_chk (
   input wire logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [3:0] wb_adr_i, wb_sel_i,
   input wire logic [31:0] wb_dat_i, txn_addr, read_data_fill,
   input wire logic txn_start, txn_upstream, txn_is_io, fwd_forward, pci_master_abort,
   input wire logic pci_read, pci_posted_write, pcie_ur_cpl, pci_target_abort,
   input wire logic posted_abort_report, sec_serr, sec_data_err, serr_forward, poison_forward
);
   logic [5:0] ctl_q;
   logic mem_en_q, system_error_forward_enable_q, mam_q;
   wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire logic vga_mem = txn_addr >= 32'h000A0000 && txn_addr <= 32'h000BFFFF;
   wire logic serr_cause = sec_serr && ctl_q[1] && system_error_forward_enable_q;
   // shadow of the control bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= 6'h00;
         mem_en_q <= 1'b0;
         system_error_forward_enable_q <= 1'b0;
         mam_q <= 1'b0;
      end else begin
         if (wr && wb_sel_i[0] && wb_adr_i == 4'h0) ctl_q <= wb_dat_i[5:0];
         if (wr && wb_sel_i[0] && wb_adr_i == 4'h4) mem_en_q <= wb_dat_i[1];
         if (wr && wb_sel_i[1] && wb_adr_i == 4'h4) system_error_forward_enable_q <= wb_dat_i[8];
         if (txn_start) mam_q <= ctl_q[5];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_once)
      else $error("ack not a single pulse");
   fill_ones_a: assert property (pci_master_abort && pci_read && !mam_q
      |=> read_data_fill == 32'hFFFFFFFF) else $error("abort read fill wrong");
   target_abort_a: assert property (pcie_ur_cpl |=> pci_target_abort == $past(mam_q))
      else $error("target abort wrong");
   posted_report_a: assert property (pci_master_abort && pci_posted_write
      |=> posted_abort_report == $past(mam_q)) else $error("posted abort report wrong");
   serr_fwd_a: assert property (serr_forward == $past(serr_cause))
      else $error("serr forward wrong");
   poison_fwd_a: assert property (sec_data_err |=> poison_forward)
      else $error("poison missing");
   vga_down_a: assert property (txn_start && !txn_upstream && !txn_is_io && vga_mem
      && ctl_q[3] && mem_en_q |=> fwd_forward) else $error("display memory not sent down");
   vga_up_a: assert property (txn_start && txn_upstream && !txn_is_io && vga_mem
      && ctl_q[3] |=> !fwd_forward) else $error("display memory sent up");
endmodule
bind bridge_forwarding_error_control bridge_forwarding_error_control_chk u_chk (.*);

// *** sim/bridge_forwarding_error_control_test.sv ***
// bench for the bridge control block: decode table, event table, registers
// assumes the far side model turns event codes into pulses
`timescale 1ns/1ps
module bridge_forwarding_error_control_test;
   typedef struct packed {logic [5:0] ctl; logic [1:0] cmd; logic [2:0] kind;
      logic [31:0] adr; logic fwd;} dec_row_t;
   typedef struct packed {logic [5:0] ctl; logic txn; logic [5:0] ev;
      logic [7:0] exp; logic [7:0] care;} ev_row_t;
   logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, txn_start, txn_upstream;
   logic txn_is_io, io_window_hit, mem_window_hit, pref_window_hit, sec_addr_err, sec_attr_err;
   logic fwd_valid, fwd_forward, pcie_ur_resp, pci_target_abort, read_all_ones, write_discard;
   logic posted_abort_report, serr_forward, sec_err_report, poison_forward, pci_master_abort;
   logic pci_read, pci_posted_write, pcie_ur_cpl, sec_serr, sec_data_err;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, txn_addr, read_data_fill, rd;
   logic [5:0] ev;
   int n_errors = 0;
   int samples_checked = 0;
   dec_row_t dec [12] = '{{6'h08,2'h2,3'h0,32'h000A0000,1'b1}, {6'h08,2'h2,3'h0,32'h000BFFFF,1'b1},
      {6'h08,2'h1,3'h0,32'h000A0000,1'b0}, {6'h0C,2'h1,3'h2,32'h000003B0,1'b1},
      {6'h08,2'h1,3'h2,32'h000003BC,1'b0}, {6'h08,2'h1,3'h2,32'h000007C0,1'b1},
      {6'h18,2'h1,3'h2,32'h000007C0,1'b0}, {6'h08,2'h3,3'h4,32'h000A0000,1'b0},
      {6'h00,2'h2,3'h1,32'h000A0000,1'b1}, {6'h04,2'h1,3'h3,32'h00000100,1'b0},
      {6'h00,2'h1,3'h3,32'h00000100,1'b1}, {6'h04,2'h1,3'h7,32'h00000100,1'b1}};
   ev_row_t evs [8] = '{{6'h23,1'b1,6'h03,8'h80,8'hC3}, {6'h23,1'b0,6'h08,8'h40,8'h40},
      {6'h23,1'b0,6'h05,8'h20,8'h20}, {6'h23,1'b0,6'h30,8'h1C,8'h1C},
      {6'h00,1'b0,6'h03,8'h80,8'h83}, {6'h00,1'b0,6'h10,8'h00,8'h10},
      {6'h00,1'b1,6'h03,8'h03,8'hC3}, {6'h00,1'b0,6'h30,8'h04,8'h1C}};
   bridge_forwarding_error_control u_bridge_forwarding_error_control (.*);
   bridge_far_side u_bridge_far_side (.*);
   always #4 ref_clk = ~ref_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, sel, input logic [31:0] d);
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, sel, d};
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic txn(input dec_row_t r);
      @(posedge ref_clk);
      {txn_start, txn_upstream, txn_is_io, io_window_hit} <= {1'b1, r.kind};
      mem_window_hit <= r.kind[0];
      txn_addr <= r.adr;
      @(posedge ref_clk);
      txn_start <= 1'b0;
      @(negedge ref_clk);
      check(fwd_valid, 32'h1);
   endtask
   task automatic fire(input logic [5:0] c);
      @(posedge ref_clk);
      ev <= c;
      @(posedge ref_clk);
      ev <= 6'h00;
      @(negedge ref_clk);
   endtask
   initial begin
      {ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, txn_start, txn_upstream, txn_is_io,
         io_window_hit, mem_window_hit, pref_window_hit, sec_addr_err, sec_attr_err,
         wb_adr_i, wb_sel_i, wb_dat_i, txn_addr, ev} = '0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 4'h0, 4'h0, 32'h3F);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 4'h0, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h3F);
      wb(1'b0, 4'hC, 4'hF, 32'h0);
      check(rd, 32'h0);
      foreach (dec[i]) begin
         wb(1'b1, 4'h0, 4'hF, {26'h0, dec[i].ctl});
         wb(1'b1, 4'h4, 4'hF, {30'h0, dec[i].cmd});
         txn(dec[i]);
         check(fwd_forward, dec[i].fwd);
      end
      wb(1'b1, 4'h4, 4'hF, 32'h100);
      foreach (evs[i]) begin
         wb(1'b1, 4'h0, 4'hF, {26'h0, evs[i].ctl});
         if (evs[i].txn) txn(dec[0]);
         fire(evs[i].ev);
         check({pcie_ur_resp, pci_target_abort, posted_abort_report, serr_forward,
            sec_err_report, poison_forward, read_all_ones, read_data_fill[0]} & evs[i].care,
            evs[i].exp);
      end
      // mode captured clear by event row 6, the last event row that runs a transaction
      fire(6'h03);
      check(read_data_fill, 32'hFFFFFFFF);
      fire(6'h01);
      check(write_discard, 32'h1);
      // attribute error with parity response captured set
      wb(1'b1, 4'h0, 4'hF, 32'h1);
      txn(dec[0]);
      @(posedge ref_clk);
      sec_attr_err <= 1'b1;
      @(posedge ref_clk);
      sec_attr_err <= 1'b0;
      @(negedge ref_clk);
      check(sec_err_report, 32'h1);
      // reset in mid-run clears the control bits
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      wb(1'b0, 4'h0, 4'hF, 32'h0);
      check(rd, 32'h0);
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      give_verdict();
   end
endmodule
